//--- hw/xpc_top.sv
// serial slave with command staging, synchronized update and status readback
`timescale 1ns/1ps
// What this block does
// - queue written commands, apply all together at the next load-marked write
// - apply pending commands as soon as a set load bit arrives
// - load applies every buffered command to all elements at one instant
// - active-low soft reset rides in second data byte; keep high normally
// - soft reset low or power-up opens all switches, outputs low
// - matching read address is acknowledged by pulling data low
// - two status bytes shifted msb first, each followed by ack slot
// - switch status bit is 1 closed, 0 open
// - output status bit equals the level driven on that output
// - bits 15..4 give xp1..xp3 as aa, ba, ab, bb
// - bit 3 output one, bit 2 output two, unused bits read 0
// - multi-switch command replaces earlier pending state of those switches
// - repeated commands on one element: only the latest counts
module xpc_top #(
	parameter logic [6:0] DEV_ADDR = xpc_pkg::XPC_DEV_ADDR,
	parameter bit HAS_GPO = 1'b1
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// serial link pins, data is open drain
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	// applied element state
	output logic [11:0] SW_CLOSED,
	output logic GPO_ONE,
	output logic GPO_TWO
);
	import xpc_pkg::*;

	// status word built from the applied state only
	function automatic logic [15:0] status_of(input xpc_state_s s);
		return {s.sw, HAS_GPO & s.general_output_one, HAS_GPO & s.general_output_two, 2'b00};
	endfunction

	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic sda_s;

	// two-stage synchronisers plus one history stage for edge finding
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			scl_q <= 3'b111;
			sda_q <= 3'b111;
		end else begin
			scl_q <= {scl_q[1:0], SCL};
			sda_q <= {sda_q[1:0], SDA_I};
		end
	end

	// link events seen from the synchronised levels
	assign sda_s = sda_q[1];
	assign scl_rise = scl_q[1] & ~scl_q[2];
	assign scl_fall = ~scl_q[1] & scl_q[2];
	assign start_c = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
	assign stop_c = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

	xpc_phase_e phase, next_phase;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [1:0] byte_idx, next_byte_idx;
	logic [7:0] shreg, next_shreg;
	logic [7:0] cmd, next_cmd;
	logic rw, next_rw;
	logic drive, next_drive;
	logic acked, next_acked;
	logic [15:0] tx, next_tx;
	xpc_state_s pending, next_pending;
	xpc_state_s applied, next_applied;
	xpc_state_s staged;
	logic [7:0] rx_byte;
	logic [15:0] status_now;

	assign rx_byte = {shreg[6:0], sda_s};
	assign status_now = status_of(applied);

	// the command in hand applied on top of what is already pending
	xpc_cmd_decode #(
		.HAS_GPO(HAS_GPO)
	) u_decode (
		.cmd(cmd),
		.cur(pending),
		.nxt(staged)
	);

	// link slave and command staging, next values
	always_comb begin
		next_phase = phase;
		next_bit_cnt = bit_cnt;
		next_byte_idx = byte_idx;
		next_shreg = shreg;
		next_cmd = cmd;
		next_rw = rw;
		next_drive = drive;
		next_acked = acked;
		next_tx = tx;
		next_pending = pending;
		next_applied = applied;
		if (start_c) begin
			next_phase = PH_RECV;
			next_bit_cnt = 3'h0;
			next_byte_idx = XPC_BYTE_ADDR;
			next_drive = 1'b0;
		end else if (stop_c) begin
			next_phase = PH_IDLE;
			next_drive = 1'b0;
		end else begin
			unique case (phase)
				PH_IDLE: begin
				end
				PH_RECV: if (scl_rise) begin
					next_shreg = rx_byte;
					next_bit_cnt = bit_cnt + 3'h1;
					if (bit_cnt == XPC_LAST_BIT) begin
						next_phase = PH_ACK;
						if (byte_idx != XPC_BYTE_EXTRA) begin
							next_byte_idx = byte_idx + 2'h1;
						end
						unique case (byte_idx)
							XPC_BYTE_ADDR: begin
								next_rw = rx_byte[0];
								if (rx_byte[7:1] != DEV_ADDR) begin
									next_phase = PH_IDLE;
								end
							end
							XPC_BYTE_CMD: next_cmd = rx_byte;
							XPC_BYTE_CTRL: begin
								if (!rx_byte[XPC_RSTN_POS]) begin
									next_pending = XPC_STATE_RST;
									next_applied = XPC_STATE_RST;
								end else begin
									next_pending = staged;
									if (rx_byte[XPC_LOAD_POS]) begin
										next_applied = staged;
									end
								end
							end
							default: next_phase = PH_IDLE;
						endcase
					end
				end
				PH_ACK: if (scl_fall) begin
					if (!drive) begin
						next_drive = 1'b1;
					end else begin
						next_drive = 1'b0;
						next_bit_cnt = 3'h0;
						if (rw) begin
							next_tx = status_now;
							next_drive = ~status_now[15];
							next_phase = PH_SEND;
						end else begin
							next_phase = PH_RECV;
						end
					end
				end
				PH_SEND: if (scl_fall) begin
					if (bit_cnt == XPC_LAST_BIT) begin
						next_drive = 1'b0;
						next_bit_cnt = 3'h0;
						next_phase = PH_MACK;
					end else begin
						next_tx = tx << 1;
						next_drive = ~tx[14];
						next_bit_cnt = bit_cnt + 3'h1;
					end
				end
				PH_MACK: begin
					if (scl_rise) begin
						next_acked = ~sda_s;
					end
					if (scl_fall) begin
						if (acked && byte_idx == XPC_BYTE_CMD) begin
							next_byte_idx = XPC_BYTE_CTRL;
							next_tx = tx << 1;
							next_drive = ~tx[14];
							next_phase = PH_SEND;
						end else begin
							next_phase = PH_IDLE;
						end
					end
				end
			endcase
		end
	end

	// link slave and command staging registers
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			phase <= PH_IDLE;
			bit_cnt <= 3'h0;
			byte_idx <= XPC_BYTE_ADDR;
			shreg <= 8'h00;
			cmd <= 8'h00;
			rw <= 1'b0;
			drive <= 1'b0;
			acked <= 1'b0;
			tx <= 16'h0000;
			pending <= XPC_STATE_RST;
			applied <= XPC_STATE_RST;
		end else begin
			phase <= next_phase;
			bit_cnt <= next_bit_cnt;
			byte_idx <= next_byte_idx;
			shreg <= next_shreg;
			cmd <= next_cmd;
			rw <= next_rw;
			drive <= next_drive;
			acked <= next_acked;
			tx <= next_tx;
			pending <= next_pending;
			applied <= next_applied;
		end
	end

	// pin and element outputs, all straight from flip-flops except SDA_O, which is tied low
	assign SDA_O = 1'b0;
	assign SDA_OE = drive;
	assign SW_CLOSED = applied.sw;
	assign GPO_ONE = applied.general_output_one;
	assign GPO_TWO = applied.general_output_two;

	// helpers for the checks below
	logic ctrl_done;
	logic addr_hit;
	assign ctrl_done = phase == PH_RECV && scl_rise && !start_c && !stop_c &&
		bit_cnt == XPC_LAST_BIT && byte_idx == XPC_BYTE_CTRL;
	assign addr_hit = phase == PH_RECV && scl_rise && !start_c && !stop_c &&
		bit_cnt == XPC_LAST_BIT && byte_idx == XPC_BYTE_ADDR &&
		rx_byte[7:1] == DEV_ADDR;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	// checks on staging, update, reset and readback
	load_apply_a: assert property (
		ctrl_done && rx_byte[XPC_LOAD_POS] && rx_byte[XPC_RSTN_POS]
		|=> applied == $past(staged) && pending == applied)
		else $error("load did not apply staged commands");
	hold_pending_a: assert property (
		ctrl_done && !rx_byte[XPC_LOAD_POS] && rx_byte[XPC_RSTN_POS]
		|=> $stable(applied) && pending == $past(staged))
		else $error("applied state moved without load");
	only_on_load_a: assert property (
		!ctrl_done |=> $stable(applied))
		else $error("applied state changed outside a control byte");
	soft_reset_a: assert property (
		ctrl_done && !rx_byte[XPC_RSTN_POS]
		|=> SW_CLOSED == 12'h000 && !GPO_ONE && !GPO_TWO)
		else $error("soft reset left elements active");
	reset_discard_a: assert property (
		ctrl_done && !rx_byte[XPC_RSTN_POS] |=> pending == XPC_STATE_RST)
		else $error("soft reset kept pending commands");
	addr_ack_a: assert property (
		addr_hit ##1 (!scl_fall && !start_c && !stop_c) [*1] ##0
		(phase == PH_ACK) |-> !SDA_OE)
		else $error("ack driven before clock fell");
	ack_drive_a: assert property (
		phase == PH_ACK && scl_fall && !drive && !start_c && !stop_c
		|=> SDA_OE)
		else $error("address ack not driven");
	snapshot_a: assert property (
		phase == PH_ACK && scl_fall && drive && rw && !start_c && !stop_c
		|=> tx == $past(status_now) && phase == PH_SEND)
		else $error("status snapshot wrong");
	msb_first_a: assert property (
		phase == PH_SEND && scl_fall && bit_cnt != XPC_LAST_BIT &&
		!start_c && !stop_c |=> tx == {$past(tx[14:0]), 1'b0} &&
		SDA_OE == !tx[15])
		else $error("status not shifted msb first");
	ack_slot_a: assert property (
		phase == PH_MACK |-> !SDA_OE)
		else $error("data driven in controller ack slot");
	status_map_a: assert property (
		status_now[1:0] == 2'b00 &&
		status_now[XPC_ST_GENERAL_OUTPUT_ONE] == (HAS_GPO & GPO_ONE) &&
		status_now[XPC_ST_GENERAL_OUTPUT_TWO] == (HAS_GPO & GPO_TWO) &&
		status_now[15:XPC_ST_SW_LSB] == SW_CLOSED)
		else $error("status word mapping wrong");

	// main scenarios
	load_seen_c: cover property (ctrl_done && rx_byte[XPC_LOAD_POS]);
	staged_seen_c: cover property (ctrl_done && !rx_byte[XPC_LOAD_POS]);
	reset_seen_c: cover property (ctrl_done && !rx_byte[XPC_RSTN_POS]);
	read_two_c: cover property (phase == PH_MACK && byte_idx == XPC_BYTE_CTRL);

endmodule

//--- hw/xpc_pkg.sv
// shared types and constants for the crosspoint command and readback block
package xpc_pkg;

	// applied or pending element state: 12 switches and two logic outputs
	typedef struct packed {
		logic [11:0] sw;
		logic general_output_one;
		logic general_output_two;
	} xpc_state_s;

	// link phase of the serial slave
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_RECV,
		PH_ACK,
		PH_SEND,
		PH_MACK
	} xpc_phase_e;

	// every switch open and both outputs low
	localparam xpc_state_s XPC_STATE_RST = '{sw: 12'h000, general_output_one: 1'b0,
		general_output_two: 1'b0};

	// bit positions in the second written data byte
	localparam int XPC_LOAD_POS = 0;
	localparam int XPC_RSTN_POS = 1;

	// bit positions inside a byte and the byte counter limits
	localparam logic [2:0] XPC_LAST_BIT = 3'h7;
	localparam logic [1:0] XPC_BYTE_ADDR = 2'h0;
	localparam logic [1:0] XPC_BYTE_CMD = 2'h1;
	localparam logic [1:0] XPC_BYTE_CTRL = 2'h2;
	localparam logic [1:0] XPC_BYTE_EXTRA = 2'h3;

	// default slave address, value is arbitrary
	localparam logic [6:0] XPC_DEV_ADDR = 7'h4c;

	// command codes carried in the low seven bits of the first data byte
	localparam logic [6:0] XPC_CMD_DIAG = 7'h60;
	localparam logic [6:0] XPC_CMD_CROSS = 7'h61;
	localparam logic [6:0] XPC_CMD_SRCA = 7'h62;
	localparam logic [6:0] XPC_CMD_SRCB = 7'h63;
	localparam logic [6:0] XPC_CMD_DSTA = 7'h64;
	localparam logic [6:0] XPC_CMD_DSTB = 7'h65;
	localparam logic [6:0] XPC_CMD_ONE_FIRST = 7'h66;
	localparam logic [6:0] XPC_CMD_ONE_LAST = 7'h71;
	localparam logic [6:0] XPC_CMD_XP_OFF_FIRST = 7'h72;
	localparam logic [6:0] XPC_CMD_XP_OFF_LAST = 7'h74;
	localparam logic [6:0] XPC_CMD_GENERAL_OUTPUT_ONE = 7'h75;
	localparam logic [6:0] XPC_CMD_GENERAL_OUTPUT_TWO = 7'h76;
	localparam logic [6:0] XPC_CMD_GPO_BOTH = 7'h77;
	localparam logic [6:0] XPC_CMD_ALL_OFF = 7'h7f;

	// per-crosspoint nibble: bit3 aa, bit2 ba, bit1 ab, bit0 bb
	localparam logic [3:0] XPC_NIB_AA = 4'h8;
	localparam logic [3:0] XPC_NIB_BA = 4'h4;
	localparam logic [3:0] XPC_NIB_AB = 4'h2;
	localparam logic [3:0] XPC_NIB_BB = 4'h1;
	localparam logic [11:0] XPC_XP1_MASK = 12'hf00;

	// status word layout
	localparam int XPC_ST_SW_LSB = 4;
	localparam int XPC_ST_GENERAL_OUTPUT_ONE = 3;
	localparam int XPC_ST_GENERAL_OUTPUT_TWO = 2;

endpackage

//--- hw/xpc_cmd_decode.sv
// applies one command byte to a staged switch and output state
`timescale 1ns/1ps
module xpc_cmd_decode #(
	parameter bit HAS_GPO = 1'b1
) (
	// command and current staged state
	input wire logic [7:0] cmd,
	input wire xpc_pkg::xpc_state_s cur,
	// staged state with the command applied
	output xpc_pkg::xpc_state_s nxt
);
	import xpc_pkg::*;

	// same nibble pattern on all three crosspoints
	function automatic logic [11:0] rep3(input logic [3:0] m);
		return {m, m, m};
	endfunction

	logic [11:0] mask;
	logic [1:0] gmask;
	logic [3:0] idx;
	logic [3:0] nib;
	logic [6:0] code;
	logic on;

	// decode the addressed elements, later commands override earlier ones
	always_comb begin
		code = cmd[6:0];
		on = cmd[7];
		mask = 12'h000;
		gmask = 2'b00;
		idx = 4'(code - XPC_CMD_ONE_FIRST);
		unique case (idx[1:0])
			2'd0: nib = XPC_NIB_AA;
			2'd1: nib = XPC_NIB_AB;
			2'd2: nib = XPC_NIB_BA;
			default: nib = XPC_NIB_BB;
		endcase
		if (code == XPC_CMD_DIAG) begin
			mask = rep3(XPC_NIB_AA | XPC_NIB_BB);
		end else if (code == XPC_CMD_CROSS) begin
			mask = rep3(XPC_NIB_AB | XPC_NIB_BA);
		end else if (code == XPC_CMD_SRCA) begin
			mask = rep3(XPC_NIB_AA | XPC_NIB_AB);
		end else if (code == XPC_CMD_SRCB) begin
			mask = rep3(XPC_NIB_BA | XPC_NIB_BB);
		end else if (code == XPC_CMD_DSTA) begin
			mask = rep3(XPC_NIB_AA | XPC_NIB_BA);
		end else if (code == XPC_CMD_DSTB) begin
			mask = rep3(XPC_NIB_AB | XPC_NIB_BB);
		end else if (code >= XPC_CMD_ONE_FIRST &&
			code <= XPC_CMD_ONE_LAST) begin
			mask = {nib, 8'h00} >> {idx[3:2], 2'b00};
		end else if (code >= XPC_CMD_XP_OFF_FIRST &&
			code <= XPC_CMD_XP_OFF_LAST) begin
			on = 1'b0; // state bit does not matter here
			mask = XPC_XP1_MASK >> {4'(code - XPC_CMD_XP_OFF_FIRST), 2'b00};
		end else if (HAS_GPO && code == XPC_CMD_GENERAL_OUTPUT_ONE) begin
			gmask = 2'b10;
		end else if (HAS_GPO && code == XPC_CMD_GENERAL_OUTPUT_TWO) begin
			gmask = 2'b01;
		end else if (HAS_GPO && code == XPC_CMD_GPO_BOTH) begin
			gmask = 2'b11;
		end else if (code == XPC_CMD_ALL_OFF && !on) begin
			mask = 12'hfff;
		end
		// unknown and reserved codes leave the staged state alone
		nxt.sw = on ? (cur.sw | mask) : (cur.sw & ~mask);
		nxt.general_output_one = gmask[1] ? on : cur.general_output_one;
		nxt.general_output_two = gmask[0] ? on : cur.general_output_two;
	end

endmodule

//--- tb/xpc_i2c_ctrl.sv
// serial link controller model that faces the crosspoint block
`timescale 1ns/1ps
module xpc_i2c_ctrl #(
	parameter logic [6:0] ADDR = xpc_pkg::XPC_DEV_ADDR
) (
	// data wire level and pull from the device
	input wire logic SDA_O,
	input wire logic SDA_OE,
	// link pins toward the device
	output logic SCL,
	output logic SDA_I
);
	logic pull = 1'b0;
	// open drain wire with pull-up, low when any party pulls
	assign SDA_I = ~pull & (SDA_OE ? SDA_O : 1'b1);
	// clock stands high outside frames
	initial SCL = 1'b1;
	// one bit slot: data set mid low phase, sampled late in high phase
	task automatic bit_x(input logic b, output logic r);
		#12 pull <= ~b;
		#12 SCL <= 1'b1;
		#20 r = SDA_I;
		#4 SCL <= 1'b0;
	endtask
	// data falls while clock is high
	task automatic start();
		#24 pull <= 1'b1;
		#24 SCL <= 1'b0;
	endtask
	// data rises while clock is high, then a bus-free gap
	task automatic stop();
		#12 pull <= 1'b1;
		#12 SCL <= 1'b1;
		#24 pull <= 1'b0;
		#48;
	endtask
	// one byte msb first plus its ack slot; ack is 1 when pulled low
	task automatic byte_x(input logic [7:0] d, input logic nak,
		output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(nak, a);
		ack = (a === 1'b0);
	endtask
	// address with write bit, command byte, control byte
	task automatic wr(input logic [7:0] cmd, input logic [7:0] ctl,
		output logic [2:0] acks);
		logic [7:0] q;
		start();
		byte_x({ADDR, 1'b0}, 1'b1, q, acks[2]);
		byte_x(cmd, 1'b1, q, acks[1]);
		byte_x(ctl, 1'b1, q, acks[0]);
		stop();
	endtask
	// start, address with read bit, two status bytes, nack last
	task automatic rd(output logic [15:0] st, output logic ack);
		logic [7:0] q;
		logic a;
		start();
		byte_x({ADDR, 1'b1}, 1'b1, q, ack);
		byte_x(8'hff, 1'b0, st[15:8], a);
		byte_x(8'hff, 1'b1, st[7:0], a);
		stop();
	endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the crosspoint command block
`timescale 1ns/1ps
module testbench;
	import xpc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic scl, sda_i, sda_o, sda_oe, general_output_one, general_output_two;
	logic [11:0] sw;
	logic [15:0] rd_word;
	logic [15:0] notes[$];
	int n_mismatch = 0;
	int compares = 0;
	int seed = 33471;
	int cycles = 0;
	event got;
	xpc_state_s appl, pend;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	xpc_top dut_u (.CLK(clk), .RESETN(resetn), .SCL(scl), .SDA_I(sda_i),
		.SDA_O(sda_o), .SDA_OE(sda_oe), .SW_CLOSED(sw), .GPO_ONE(general_output_one),
		.GPO_TWO(general_output_two));
	xpc_i2c_ctrl m_u (.SDA_O(sda_o), .SDA_OE(sda_oe), .SCL(scl),
		.SDA_I(sda_i));
	// single compare with count and report
	task automatic cmp16(input string what, input logic [15:0] e,
		input logic [15:0] s);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask
	// status word expected from an element state
	function automatic logic [15:0] stat(xpc_state_s s);
		return {s.sw, s.general_output_one, s.general_output_two, 2'b00};
	endfunction
	// reference effect of one command byte on a staged state
	function automatic xpc_state_s apply(xpc_state_s s, logic [7:0] c);
		int ord[4] = '{0, 2, 1, 3};
		int k;
		logic v;
		v = c[7];
		k = int'(c[6:0]) - int'(XPC_CMD_ONE_FIRST);
		case (c[6:0])
			7'h60: for (int x = 0; x < 3; x++) begin
				{s.sw[11-4*x], s.sw[8-4*x]} = {v, v};
			end
			7'h61: for (int x = 0; x < 3; x++) begin
				{s.sw[10-4*x], s.sw[9-4*x]} = {v, v};
			end
			7'h62: for (int x = 0; x < 3; x++) begin
				{s.sw[11-4*x], s.sw[9-4*x]} = {v, v};
			end
			7'h63: for (int x = 0; x < 3; x++) begin
				{s.sw[10-4*x], s.sw[8-4*x]} = {v, v};
			end
			7'h64: for (int x = 0; x < 3; x++) begin
				{s.sw[11-4*x], s.sw[10-4*x]} = {v, v};
			end
			7'h65: for (int x = 0; x < 3; x++) begin
				{s.sw[9-4*x], s.sw[8-4*x]} = {v, v};
			end
			7'h72: s.sw[11:8] = 4'h0;
			7'h73: s.sw[7:4] = 4'h0;
			7'h74: s.sw[3:0] = 4'h0;
			7'h75: s.general_output_one = v;
			7'h76: s.general_output_two = v;
			7'h77: {s.general_output_one, s.general_output_two} = {v, v};
			7'h7f: if (!v) s.sw = 12'h000;
			default: if (k >= 0 && k < 12) begin
				s.sw[11-4*(k/4)-ord[k%4]] = v;
			end
		endcase
		return s;
	endfunction
	// one write transfer, then update of the reference copies
	task automatic send(logic [7:0] c, logic ld, logic rn);
		logic [2:0] a;
		m_u.wr(c, {6'h00, rn, ld}, a);
		cmp16("write acks", 16'h0007, {13'h0000, a});
		if (!rn) begin
			appl = XPC_STATE_RST;
			pend = appl;
		end else begin
			pend = apply(pend, c);
			if (ld) appl = pend;
		end
	endtask
	// one read transfer; expectation noted before the result appears
	task automatic check();
		logic a;
		notes.push_back(stat(appl));
		m_u.rd(rd_word, a);
		cmp16("read ack", 16'h0001, {15'h0000, a});
		-> got;
	endtask
	// watcher pairs each read result with the oldest note
	always @(got) begin
		logic [15:0] e;
		e = notes.pop_front();
		cmp16("status word", e, rd_word);
		cmp16("element pins", e, {sw, general_output_one, general_output_two, 2'b00});
	end
	// verdict and end of run
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// main sequence
	initial begin
		int r;
		logic [7:0] c;
		appl = XPC_STATE_RST;
		pend = appl;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check();
		$display("test power-up state done");
		// grouped random single-switch commands, load on the last
		for (int n = 0; n < 6; n++) begin
			r = $random(seed);
			c = {r[7], 7'h66 + 7'(r[15:8] % 12)};
			send(c, n == 5, 1'b1);
			if (n == 2) check();
		end
		check();
		send(8'he6, 1'b0, 1'b1);
		send(8'h66, 1'b1, 1'b1);
		check();
		$display("test grouped update done");
		send(8'he0, 1'b1, 1'b1);
		check();
		send(8'h72, 1'b0, 1'b1);
		send(8'he1, 1'b1, 1'b1);
		check();
		send(8'he2, 1'b0, 1'b1);
		send(8'he5, 1'b0, 1'b1);
		send(8'hf3, 1'b1, 1'b1);
		check();
		send(8'he3, 1'b0, 1'b1);
		send(8'h64, 1'b0, 1'b1);
		send(8'h90, 1'b0, 1'b1);
		send(8'h74, 1'b1, 1'b1);
		check();
		$display("test multi-switch commands done");
		send(8'hf7, 1'b0, 1'b1);
		send(8'h76, 1'b1, 1'b1);
		check();
		send(8'h75, 1'b1, 1'b1);
		send(8'hf5, 1'b1, 1'b1);
		check();
		$display("test general outputs done");
		// hardware reset in mid-run with a command still pending
		send(8'he1, 1'b0, 1'b1);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		appl = XPC_STATE_RST;
		pend = appl;
		repeat (4) @(posedge clk);
		check();
		send(8'hff, 1'b1, 1'b1);
		check();
		$display("test mid-run reset done");
		send(8'he0, 1'b0, 1'b1);
		send(8'h00, 1'b0, 1'b0);
		check();
		send(8'hff, 1'b1, 1'b1);
		check();
		$display("test soft reset done");
		@(posedge clk);
		tally_and_finish();
	end
endmodule
